// file: rtl/peb_pkg.sv
// constants, attribute positions and types for the peripheral extension bridge
package peb_pkg;
    // configuration record byte offsets
    localparam int unsigned OFS_VERSION    = 0;
    localparam int unsigned OFS_BUS_PARAM  = 1;
    localparam int unsigned OFS_META_LEN   = 5;
    localparam int unsigned OFS_CAPACITY   = 7;
    localparam int unsigned OFS_META_DATA  = 11;
    localparam int unsigned CFG_BYTES      = 64;
    localparam int unsigned CFG_AW         = 6;
    localparam logic [7:0]  CFG_VERSION    = 8'h02;
    localparam logic [7:0]  CFG_RESET_BYTE = 8'h00;
    // bus parameter word fields
    localparam int unsigned BP_MEMORY_BIT  = 31;
    localparam int unsigned BP_HALF_LSB    = 0;
    // handle types and reserved index range
    localparam logic [7:0]  EXT_HT         = 8'h11;
    localparam logic [31:0] IDX_BASE       = 32'h01C40000;
    localparam logic [31:0] IDX_LAST       = 32'h01C4000F;
    localparam int unsigned N_PINS         = 16;
    // attribute bit positions
    localparam int unsigned A_PPWRITE      = 0;
    localparam int unsigned A_OWNERWRITE   = 1;
    localparam int unsigned A_AUTHWRITE    = 2;
    localparam int unsigned A_POLICYWRITE  = 3;
    localparam int unsigned A_NT_LSB       = 4;
    localparam int unsigned A_POLICYDEL    = 10;
    localparam int unsigned A_GLOBALLOCK   = 15;
    localparam int unsigned A_OWNERREAD    = 17;
    localparam int unsigned A_AUTHREAD     = 18;
    localparam int unsigned A_NO_DA        = 25;
    localparam int unsigned A_ORDERLY      = 26;
    localparam int unsigned A_CLEAR_ST     = 27;
    localparam int unsigned A_PLATCREATE   = 30;
    localparam int unsigned A_READ_ST      = 31;
    localparam logic [3:0]  NT_ORDINARY    = 4'h0;
    // command and response codes
    localparam logic [1:0]  OP_DEFINE      = 2'h0;
    localparam logic [1:0]  OP_READ        = 2'h1;
    localparam logic [1:0]  OP_WRITE       = 2'h2;
    localparam logic [2:0]  RSP_OK         = 3'h0;
    localparam logic [2:0]  RSP_ATTR       = 3'h1;
    localparam logic [2:0]  RSP_HANDLE     = 3'h2;
    localparam logic [2:0]  RSP_UNBOUND    = 3'h3;
    localparam logic [2:0]  RSP_NOCFG      = 3'h4;
    // serial frame opcodes sent ahead of the opaque payload
    localparam logic [7:0]  SER_OP_READ    = 8'h03;
    localparam logic [7:0]  SER_OP_WRITE   = 8'h02;
    // serial clock timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned LINK_PERIOD_NS = 160;
    localparam logic [7:0]  LINK_HALF_CYC  = 8'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [31:0] COUNT_RESET    = 32'h00000000;

    typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_NEXT, ST_FETCH, ST_FINISH} peb_state_t;
endpackage

// file: rtl/peb_bridge.sv
// storage command bridge from reserved indices to a serial peripheral on gpio pins
// Summary of operation
// - config byte 0 is the structure version and must equal 02h.
// - config bytes 1 to 4 are the vendor bus parameter word.
// - config bytes 5 and 6 give the metadata area length.
// - for memory peripherals bytes 7 to 10 give capacity in kilobytes.
// - metadata starts at byte 11 and spans metadata length bytes.
// - config index may be defined with external storage handle type 11h.
// - config index must be defined with the opaque index type.
// - config index attributes: listed ones cleared, others set as prescribed.
// - accept defining data indices with the peripheral index handle type.
// - storage commands on peripheral indices become serial transactions.
// - write response waits until downstream write has completed.
// - read response waits until all data arrived from downstream.
// - non-memory data indices need orderly cleared and platform-create set.
// - non-memory data indices use the opaque index type.
// - defining an index in the reserved range binds it to a pin.
// - payload passes through uninterpreted; bridge only authenticates access.
// - peripheral attaches to gpio pins over a serial bus.
// - each peripheral index keeps a change count starting at zero.
// - every write updates the index count and finally the top count; the bridge steps both counts in the same cycle, in ST_FINISH.
// - pins map one-to-one to indices 01C40000h to 01C4000Fh.
// - a memory peripheral needs a non-zero capacity field.
`timescale 1ns/10ps
module peb_bridge #(
    parameter logic [7:0] PERIPH_HT = 8'h01
)(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cfg_we_i,
    input  wire logic [5:0]  cfg_addr_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    output logic             cfg_ok_o,
    input  wire logic        cmd_valid_i,
    input  wire logic [1:0]  cmd_op_i,
    input  wire logic [31:0] cmd_handle_i,
    input  wire logic [31:0] cmd_attr_i,
    input  wire logic [7:0]  cmd_len_i,
    output logic             cmd_ready_o,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    output logic      [7:0]  rd_data_o,
    output logic             rd_valid_o,
    output logic             rsp_valid_o,
    output logic      [2:0]  rsp_code_o,
    output logic             sck_o,
    output logic             mosi_o,
    input  wire logic        miso_i,
    output logic      [15:0] gpio_cs_n_o,
    output logic      [31:0] top_count_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]             cfg_mem [0:peb_pkg::CFG_BYTES-1];
    logic [7:0]             cfg_rdata_reg;
    logic                   cfg_ok_reg;
    logic                   cfg_defined_reg;
    logic [15:0]            bound_reg;
    logic                   cmd_ready_reg;
    logic                   wr_ready_reg;
    logic [7:0]             rd_data_reg;
    logic                   rd_valid_reg;
    logic                   rsp_valid_reg;
    logic [2:0]             rsp_code_reg;
    logic                   sck_reg;
    logic                   mosi_reg;
    logic [15:0]            cs_n_reg;
    logic [31:0]            top_count_reg;
    logic [31:0]            idx_count_reg [0:peb_pkg::N_PINS-1];
    peb_pkg::peb_state_t    state_reg;
    logic [7:0]             half_cnt_reg;
    logic [2:0]             bit_cnt_reg;
    logic [7:0]             sh_out_reg;
    logic [7:0]             sh_in_reg;
    logic [7:0]             left_reg;
    logic                   hdr_reg;
    logic                   is_write_reg;
    logic [3:0]             cur_idx_reg;
    logic                   miso_s1_reg;
    logic                   miso_s2_reg;
    logic                   miso_s3_reg;
    logic                   miso_val_reg;

    logic [15:0]            meta_len;
    logic [31:0]            bus_param;
    logic [31:0]            capacity;
    logic                   is_memory;
    logic [7:0]             half_cyc;
    logic                   cfg_ok_next;
    logic                   cfg_wr_allowed;
    logic                   take;
    logic                   in_range;
    logic [3:0]             idx;
    logic [3:0]             ntype;
    logic [2:0]             def_code;
    logic                   def_is_cfg;
    logic [2:0]             xfer_code;

    ////////////////////////////////////////////////////////////////////////////
    // configuration record decode, big-endian multi-byte fields
    assign meta_len  = {cfg_mem[peb_pkg::OFS_META_LEN], cfg_mem[peb_pkg::OFS_META_LEN+1]};
    assign bus_param = {cfg_mem[peb_pkg::OFS_BUS_PARAM],   cfg_mem[peb_pkg::OFS_BUS_PARAM+1],
                        cfg_mem[peb_pkg::OFS_BUS_PARAM+2], cfg_mem[peb_pkg::OFS_BUS_PARAM+3]};
    assign capacity  = {cfg_mem[peb_pkg::OFS_CAPACITY],   cfg_mem[peb_pkg::OFS_CAPACITY+1],
                        cfg_mem[peb_pkg::OFS_CAPACITY+2], cfg_mem[peb_pkg::OFS_CAPACITY+3]};
    assign is_memory = bus_param[peb_pkg::BP_MEMORY_BIT];
    // zero half period falls back to the default serial rate
    assign half_cyc  = (bus_param[peb_pkg::BP_HALF_LSB +: 8] == 8'h00) ?
                       peb_pkg::LINK_HALF_CYC : bus_param[peb_pkg::BP_HALF_LSB +: 8];
    assign cfg_ok_next = (cfg_mem[peb_pkg::OFS_VERSION] == peb_pkg::CFG_VERSION)
                         && (!is_memory || capacity != 32'h00000000);
    // metadata bytes past the declared length are not writable
    assign cfg_wr_allowed = ({10'h000, cfg_addr_i} < 16'(peb_pkg::OFS_META_DATA))
                            || ({10'h000, cfg_addr_i} - 16'(peb_pkg::OFS_META_DATA) < meta_len);

    genvar gi;
    generate
        for (gi = 0; gi < peb_pkg::CFG_BYTES; gi++)
        begin : g_cfg
            always_ff @(posedge mclk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    cfg_mem[gi] <= peb_pkg::CFG_RESET_BYTE;
                else if (cfg_we_i && cfg_wr_allowed && cfg_addr_i == 6'(gi))
                    cfg_mem[gi] <= cfg_wdata_i;
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg_rdata_reg <= 8'h00;
            cfg_ok_reg    <= 1'b0;
        end
        else
        begin
            cfg_rdata_reg <= cfg_mem[cfg_addr_i];
            cfg_ok_reg    <= cfg_ok_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command checks
    assign take     = cmd_valid_i && cmd_ready_reg && state_reg == peb_pkg::ST_IDLE;
    assign in_range = cmd_handle_i[31:24] == PERIPH_HT
                      && cmd_handle_i >= peb_pkg::IDX_BASE && cmd_handle_i <= peb_pkg::IDX_LAST;
    assign idx      = cmd_handle_i[3:0];
    assign ntype    = cmd_attr_i[peb_pkg::A_NT_LSB +: 4];
    assign def_is_cfg = cmd_handle_i[31:24] == peb_pkg::EXT_HT;

    always_comb
    begin
        def_code = peb_pkg::RSP_OK;
        if (def_is_cfg)
        begin
            if (ntype != peb_pkg::NT_ORDINARY
                || cmd_attr_i[peb_pkg::A_AUTHWRITE] || cmd_attr_i[peb_pkg::A_OWNERWRITE]
                || cmd_attr_i[peb_pkg::A_GLOBALLOCK] || cmd_attr_i[peb_pkg::A_CLEAR_ST]
                || cmd_attr_i[peb_pkg::A_ORDERLY] || cmd_attr_i[peb_pkg::A_READ_ST]
                || !cmd_attr_i[peb_pkg::A_PLATCREATE] || !cmd_attr_i[peb_pkg::A_AUTHREAD]
                || !cmd_attr_i[peb_pkg::A_OWNERREAD] || !cmd_attr_i[peb_pkg::A_NO_DA])
                def_code = peb_pkg::RSP_ATTR;
        end
        else if (!in_range)
            def_code = peb_pkg::RSP_HANDLE;
        else if (!cfg_defined_reg || !cfg_ok_reg)
            def_code = peb_pkg::RSP_NOCFG;
        else if (!is_memory && (ntype != peb_pkg::NT_ORDINARY
                 || cmd_attr_i[peb_pkg::A_ORDERLY] || !cmd_attr_i[peb_pkg::A_PLATCREATE]))
            def_code = peb_pkg::RSP_ATTR;
    end

    always_comb
    begin
        xfer_code = peb_pkg::RSP_OK;
        if (!in_range)
            xfer_code = peb_pkg::RSP_HANDLE;
        else if (!cfg_ok_reg)
            xfer_code = peb_pkg::RSP_NOCFG;
        else if (!bound_reg[idx])
            xfer_code = peb_pkg::RSP_UNBOUND;
    end

    // index definitions bind the matching pin
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg_defined_reg <= 1'b0;
            bound_reg       <= 16'h0000;
        end
        else if (take && cmd_op_i == peb_pkg::OP_DEFINE && def_code == peb_pkg::RSP_OK)
        begin
            if (def_is_cfg)
                cfg_defined_reg <= 1'b1;
            else
                bound_reg[idx] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial data input synchroniser
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            miso_s1_reg  <= 1'b0;
            miso_s2_reg  <= 1'b0;
            miso_s3_reg  <= 1'b0;
            miso_val_reg <= 1'b0;
        end
        else
        begin
            miso_s1_reg <= miso_i;
            miso_s2_reg <= miso_s1_reg;
            miso_s3_reg <= miso_s2_reg;
            if (miso_s2_reg == miso_s3_reg)
                miso_val_reg <= miso_s3_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command sequencer and serial engine, mode 0, msb first
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg     <= peb_pkg::ST_IDLE;
            cmd_ready_reg <= 1'b0;
            wr_ready_reg  <= 1'b0;
            rd_data_reg   <= 8'h00;
            rd_valid_reg  <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_code_reg  <= peb_pkg::RSP_OK;
            sck_reg       <= 1'b0;
            mosi_reg      <= 1'b0;
            cs_n_reg      <= 16'hFFFF;
            half_cnt_reg  <= 8'h00;
            bit_cnt_reg   <= 3'h0;
            sh_out_reg    <= 8'h00;
            sh_in_reg     <= 8'h00;
            left_reg      <= 8'h00;
            hdr_reg       <= 1'b0;
            is_write_reg  <= 1'b0;
            cur_idx_reg   <= 4'h0;
        end
        else
        begin
            rsp_valid_reg <= 1'b0;
            rd_valid_reg  <= 1'b0;
            case (state_reg)
                peb_pkg::ST_IDLE:
                begin
                    cmd_ready_reg <= !take;
                    if (take && cmd_op_i == peb_pkg::OP_DEFINE)
                    begin
                        rsp_valid_reg <= 1'b1;
                        rsp_code_reg  <= def_code;
                    end
                    else if (take && xfer_code != peb_pkg::RSP_OK)
                    begin
                        rsp_valid_reg <= 1'b1;
                        rsp_code_reg  <= xfer_code;
                    end
                    else if (take)
                    begin
                        is_write_reg <= cmd_op_i == peb_pkg::OP_WRITE;
                        sh_out_reg   <= (cmd_op_i == peb_pkg::OP_WRITE) ?
                                        peb_pkg::SER_OP_WRITE : peb_pkg::SER_OP_READ;
                        mosi_reg     <= 1'b0;
                        cs_n_reg     <= ~(16'h0001 << idx);
                        cur_idx_reg  <= idx;
                        left_reg     <= cmd_len_i;
                        hdr_reg      <= 1'b1;
                        half_cnt_reg <= 8'h00;
                        bit_cnt_reg  <= 3'h0;
                        state_reg    <= peb_pkg::ST_SHIFT;
                    end
                end
                peb_pkg::ST_SHIFT:
                begin
                    mosi_reg <= sh_out_reg[7];
                    if (half_cnt_reg >= half_cyc - 8'h01)
                    begin
                        half_cnt_reg <= 8'h00;
                        sck_reg      <= ~sck_reg;
                        if (!sck_reg)
                            sh_in_reg <= {sh_in_reg[6:0], miso_val_reg};
                        else
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            sh_out_reg  <= {sh_out_reg[6:0], 1'b0};
                            if (bit_cnt_reg == 3'h7)
                                state_reg <= peb_pkg::ST_NEXT;
                        end
                    end
                    else
                        half_cnt_reg <= half_cnt_reg + 8'h01;
                end
                peb_pkg::ST_NEXT:
                begin
                    hdr_reg <= 1'b0;
                    if (!hdr_reg && !is_write_reg)
                    begin
                        rd_data_reg  <= sh_in_reg;
                        rd_valid_reg <= 1'b1;
                    end
                    if (left_reg == 8'h00)
                    begin
                        cs_n_reg  <= 16'hFFFF;
                        state_reg <= peb_pkg::ST_FINISH;
                    end
                    else
                    begin
                        left_reg <= left_reg - 8'h01;
                        if (is_write_reg)
                        begin
                            wr_ready_reg <= 1'b1;
                            state_reg    <= peb_pkg::ST_FETCH;
                        end
                        else
                        begin
                            sh_out_reg <= 8'h00;
                            state_reg  <= peb_pkg::ST_SHIFT;
                        end
                    end
                end
                peb_pkg::ST_FETCH:
                begin
                    if (wr_valid_i && wr_ready_reg)
                    begin
                        wr_ready_reg <= 1'b0;
                        sh_out_reg   <= wr_data_i;
                        state_reg    <= peb_pkg::ST_SHIFT;
                    end
                end
                peb_pkg::ST_FINISH:
                begin
                    // answer only once the peripheral select has been released
                    rsp_valid_reg <= 1'b1;
                    rsp_code_reg  <= peb_pkg::RSP_OK;
                    state_reg     <= peb_pkg::ST_IDLE;
                end
                default:
                    state_reg <= peb_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rollback change counts, one per index plus the internal top count
    generate
        for (gi = 0; gi < peb_pkg::N_PINS; gi++)
        begin : g_cnt
            always_ff @(posedge mclk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    idx_count_reg[gi] <= peb_pkg::COUNT_RESET;
                else if (state_reg == peb_pkg::ST_FINISH && is_write_reg && cur_idx_reg == 4'(gi))
                    idx_count_reg[gi] <= idx_count_reg[gi] + 32'h00000001;
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            top_count_reg <= peb_pkg::COUNT_RESET;
        else if (state_reg == peb_pkg::ST_FINISH && is_write_reg)
            top_count_reg <= top_count_reg + 32'h00000001;
    end

    assign cfg_rdata_o = cfg_rdata_reg;
    assign cfg_ok_o    = cfg_ok_reg;
    assign cmd_ready_o = cmd_ready_reg;
    assign wr_ready_o  = wr_ready_reg;
    assign rd_data_o   = rd_data_reg;
    assign rd_valid_o  = rd_valid_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_code_o  = rsp_code_reg;
    assign sck_o       = sck_reg;
    assign mosi_o      = mosi_reg;
    assign gpio_cs_n_o = cs_n_reg;
    assign top_count_o = top_count_reg;

    ////////////////////////////////////////////////////////////////////////////
    xfer_rsp_after_cs_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (rsp_valid_o && rsp_code_o == peb_pkg::RSP_OK && $past(state_reg) == peb_pkg::ST_FINISH)
        |-> gpio_cs_n_o == 16'hFFFF && $past(gpio_cs_n_o) == 16'hFFFF)
        else $error("ok response while peripheral still selected");
    read_data_in_frame_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_valid_o |-> !is_write_reg ##1 (!rsp_valid_o || gpio_cs_n_o == 16'hFFFF))
        else $error("read data outside a read frame");
    select_bound_only_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        gpio_cs_n_o != 16'hFFFF |-> !bound_reg[cur_idx_reg] == 1'b0
            && gpio_cs_n_o == ~(16'h0001 << cur_idx_reg))
        else $error("select on an unbound or wrong pin");
    no_frame_bad_cfg_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(gpio_cs_n_o[cur_idx_reg]) |-> $past(cfg_ok_reg))
        else $error("frame opened with invalid configuration");
    version_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cfg_mem[peb_pkg::OFS_VERSION] != peb_pkg::CFG_VERSION ##1
            cfg_mem[peb_pkg::OFS_VERSION] != peb_pkg::CFG_VERSION |-> !cfg_ok_o)
        else $error("record accepted with wrong version");
    memory_capacity_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cfg_ok_o |-> $past(!is_memory || capacity != 32'h00000000))
        else $error("memory record accepted with zero capacity");
    write_count_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == peb_pkg::ST_FINISH && is_write_reg) |=>
            top_count_o == $past(top_count_o) + 32'h00000001 && rsp_valid_o)
        else $error("write finished without count update");
    index_count_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == peb_pkg::ST_FINISH && is_write_reg) |=>
            idx_count_reg[cur_idx_reg] == $past(idx_count_reg[cur_idx_reg]) + 32'h00000001)
        else $error("index change count not stepped");
    sck_idle_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (gpio_cs_n_o == 16'hFFFF)[*2] |-> !sck_o)
        else $error("serial clock active with no select");
    define_orderly_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (take && cmd_op_i == peb_pkg::OP_DEFINE && !def_is_cfg && !is_memory
            && cmd_attr_i[peb_pkg::A_ORDERLY]) |=> rsp_valid_o && rsp_code_o != peb_pkg::RSP_OK)
        else $error("orderly data index accepted");
endmodule

// file: sim/peb_spi_model.sv
// serial peripheral model on the bridge's select, clock and data pins
`timescale 1ns/10ps
module peb_spi_model (
    input  wire logic        sck_i,
    input  wire logic        mosi_i,
    input  wire logic [15:0] cs_n_i,
    output logic             miso_o,
    output logic      [15:0] rx_o
);
    localparam logic [7:0] TX_BYTE = 8'h3C;
    logic       idle;
    logic [2:0] bit_q;
    logic       last_q = 1'b0;
    assign idle = &cs_n_i;
    // mode 0: capture on the rising edge, payload kept opaque
    always @(posedge sck_i) if (!idle) rx_o <= {rx_o[14:0], mosi_i};
    // next bit goes out after each falling edge, restart on deselect
    always @(negedge sck_i or posedge idle) bit_q <= idle ? 3'h0 : bit_q + 3'h1;
    always @(miso_o) if (!idle) last_q <= miso_o;
    // released line shows the inverse of the last driven bit
    assign miso_o = idle ? ~last_q : TX_BYTE[3'h7 - bit_q];
endmodule

// file: sim/peb_bridge_tb.sv
// self-checking bench for the peripheral extension bridge
`timescale 1ns/10ps
module peb_bridge_tb;
    logic        mclk_i = 0, sys_rst_i = 1, cfg_we_i = 0, cmd_valid_i = 0, wr_valid_i = 0;
    logic        cfg_ok_o, cmd_ready_o, wr_ready_o, rd_valid_o, rsp_valid_o;
    logic        sck_o, mosi_o, miso_i;
    logic [5:0]  cfg_addr_i = 6'h00;
    logic [7:0]  cfg_wdata_i = 8'h00, cmd_len_i = 8'h01, wr_data_i = 8'h00, cfg_rdata_o, rd_data_o;
    logic [1:0]  cmd_op_i = 2'h0;
    logic [2:0]  rsp_code_o;
    logic [31:0] cmd_handle_i = 32'h0, cmd_attr_i = 32'h0, top_count_o;
    logic [15:0] gpio_cs_n_o, rx, sel;
    logic [7:0]  rd;
    int          n_errors = 0, checks = 0, cyc = 0;
    peb_bridge peb_bridge_i (.mclk_i, .sys_rst_i, .cfg_we_i, .cfg_addr_i, .cfg_wdata_i,
        .cfg_rdata_o, .cfg_ok_o, .cmd_valid_i, .cmd_op_i, .cmd_handle_i, .cmd_attr_i, .cmd_len_i,
        .cmd_ready_o, .wr_data_i, .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o, .rsp_valid_o,
        .rsp_code_o, .sck_o, .mosi_o, .miso_i, .gpio_cs_n_o, .top_count_o);
    peb_spi_model peb_spi_model_i (.sck_i(sck_o), .mosi_i(mosi_o), .cs_n_i(gpio_cs_n_o),
        .miso_o(miso_i), .rx_o(rx));
    initial forever #5 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge mclk_i) if (++cyc == 20000)
    begin
        n_errors++;
        $display("mismatch at %0t: timeout", $time);
        complete_run;
    end
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic cfg(input logic [5:0] a, input logic [7:0] d);
        cfg_we_i <= 1; cfg_addr_i <= a; cfg_wdata_i <= d;
        @(posedge mclk_i) cfg_we_i <= 0;
        repeat (3) @(posedge mclk_i);
    endtask
    // issue one command, serve write bytes, wait for the response and judge its code
    task automatic cmd(input logic [1:0] op, input logic [31:0] h, a, input logic [2:0] code);
        int  n;
        logic rdy;
        rdy = 0; sel = 16'h0;
        while (cmd_ready_o !== 1'b1) @(posedge mclk_i);
        cmd_valid_i <= 1; cmd_op_i <= op; cmd_handle_i <= h; cmd_attr_i <= a;
        @(posedge mclk_i) cmd_valid_i <= 0;
        for (n = 0; n < 4000 && rsp_valid_o !== 1'b1; n++)
        begin
            if (wr_valid_i && rdy) wr_valid_i <= 0;
            else if (wr_ready_o === 1'b1) {wr_valid_i, wr_data_i} <= {1'b1, 8'hA5};
            rdy = wr_ready_o;
            if (rd_valid_o === 1'b1) rd = rd_data_o;
            sel = sel | ~gpio_cs_n_o;
            @(posedge mclk_i);
        end
        chk(rsp_code_o === code && n < 4000, "response code");
        chk(gpio_cs_n_o === 16'hFFFF, "select still low at response");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_config;
        cfg(6'h00, 8'h03);
        chk(cfg_ok_o === 1'b0, "wrong version accepted");
        cfg(6'h00, 8'h02);
        chk(cfg_ok_o === 1'b1 && cfg_rdata_o === 8'h02, "version 02 refused");
        cfg(6'h01, 8'h80);
        chk(cfg_ok_o === 1'b0, "memory record with zero capacity");
        cfg(6'h0A, 8'h01);
        chk(cfg_ok_o === 1'b1, "memory record with capacity refused");
        cfg(6'h0B, 8'h77);
        chk(cfg_rdata_o === 8'h00, "metadata written past length");
        cfg(6'h06, 8'h01);
        cfg(6'h0B, 8'h77);
        chk(cfg_rdata_o === 8'h77, "metadata within length refused");
        cfg(6'h01, 8'h00);
        chk(cfg_ok_o === 1'b1, "non-memory record refused");
        $display("test_config done");
    endtask
    task automatic test_define;
        logic [31:0] h[6] = '{32'h11000000, 32'h11000000, 32'h02C40000,
                              32'h01C40000, 32'h01C40000, 32'h01C40000};
        logic [31:0] a[6] = '{32'h42060005, 32'h42060001, 32'h40000000,
                              32'h44000000, 32'h40000010, 32'h40000000};
        logic [2:0]  c[6] = '{3'h1, 3'h0, 3'h2, 3'h1, 3'h1, 3'h0};
        for (int i = 0; i < 6; i++) cmd(2'h0, h[i], a[i], c[i]);
        $display("test_define done");
    endtask
    task automatic test_transfer;
        cmd(2'h2, 32'h01C40000, 32'h0, 3'h0);
        chk(rx === 16'h02A5 && sel === 16'h0001, "write frame or pin");
        chk(top_count_o === 32'h00000001, "change count");
        cmd(2'h1, 32'h01C40000, 32'h0, 3'h0);
        chk(rx[15:8] === 8'h03 && rd === 8'h3C, "read frame or data");
        cmd(2'h1, 32'h01C40003, 32'h0, 3'h3);
        $display("test_transfer done");
    endtask
    task automatic test_bad_record;
        cfg(6'h00, 8'h05);
        cmd(2'h1, 32'h01C40000, 32'h0, 3'h4);
        chk(sel === 16'h0000, "channel opened without valid record");
        $display("test_bad_record done");
    endtask
    initial
    begin
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 0;
        repeat (2) @(posedge mclk_i);
        test_config;
        test_define;
        test_transfer;
        test_bad_record;
        complete_run;
    end
endmodule
